// File: logic/pidreg_top.sv
// Purpose: identification registers, pin alternate-function select and backup charger config
// Assumes: byte register port from the serial interface engine; one access per cycle at most
// Notes: register port refuses accesses until the factory load has finished
`timescale 1ns/1ps

// What this block does
// R1 - alt bit 3 set makes pin 3 the power-good input, else plain second-direction pin
// R2 - alt bits 2..0 set make their pins active-high sequencer outputs
// R3 - alt bits 2..0 clear make pins plain I/O steered by first direction select
// R4 - a 24-bit serial number is shown over three 8-bit registers
// R5 - serial low byte at lowest address, middle next, high byte third
// R6 - an 8-bit option tracking register reports the factory configuration code
// R7 - chip id bits 7..4 show the metal revision fixed by silicon; here a register write can overwrite them
// R8 - chip id bits 3..0 show production status loaded from factory memory
// R9 - charger config bit 0 switches the backup charger on or off
// R10 - charger config holds resistor, low-current disable, voltage and current fields
// R11 - factory-loaded registers are filled before the port takes its first access
module pidreg_top
  import pidreg_pkg::*;
#(
  // silicon metal revision; value is arbitrary
  parameter logic [3:0] METAL_REVISION = 4'hA
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic o_reg_ready,
  output logic o_reg_rvalid,
  output logic [7:0] o_reg_rdata,
  // factory memory
  output logic o_otp_rd,
  output logic [2:0] o_otp_addr,
  input wire logic [7:0] i_otp_data,
  // pin direction settings held elsewhere, 1 means input
  input wire logic i_first_direction_select,
  input wire logic i_second_direction_select,
  // pin data from general-purpose output logic and sequencer
  input wire logic [3:0] i_gpo_level,
  input wire logic [2:0] i_seq_out,
  // pins 0..3
  input wire logic [3:0] i_pin_in,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe,
  // pin observations
  output logic [3:0] o_gpi_level,
  output logic o_external_power_good_input,
  // charger controls
  output logic o_charger_on,
  output logic [1:0] o_charger_resistor_select,
  output logic o_charger_low_current_disable,
  output logic [1:0] o_charger_voltage_select,
  output logic [1:0] o_charger_current_select
);

  // map an address to the bank index; shared by the write and read paths
  function automatic pidreg_idx_e pidreg_decode(input logic [7:0] addr);
    pidreg_idx_e idx;
    idx = PIDREG_IDX_NONE;
    if (addr == PIDREG_ADDR_ALT_FUNC)
      idx = PIDREG_IDX_ALT_FUNC;
    else if (addr == PIDREG_ADDR_CHARGER)
      idx = PIDREG_IDX_CHARGER;
    else if (addr == PIDREG_ADDR_SERIAL_LOW)
      idx = PIDREG_IDX_SERIAL_LOW;
    else if (addr == PIDREG_ADDR_SERIAL_MID)
      idx = PIDREG_IDX_SERIAL_MID;
    else if (addr == PIDREG_ADDR_SERIAL_HIGH)
      idx = PIDREG_IDX_SERIAL_HIGH;
    else if (addr == PIDREG_ADDR_REV_STATUS)
      idx = PIDREG_IDX_REV_STATUS;
    else if (addr == PIDREG_ADDR_OPTION)
      idx = PIDREG_IDX_OPTION;
    return idx;
  endfunction

  logic load_valid;
  logic [2:0] load_word;
  logic [7:0] load_data;
  logic load_done;
  logic wr_ok;
  logic rd_ok;
  pidreg_idx_e wr_idx;
  pidreg_idx_e rd_idx;

  logic [7:0] alt_func_r;
  logic [7:0] serial_low_r;
  logic [7:0] serial_mid_r;
  logic [7:0] serial_high_r;
  logic [3:0] metal_rev_r;
  logic [3:0] prod_status_r;
  logic [7:0] option_r;
  logic [7:0] charger_r;
  logic [7:0] rdata_nxt;

  // factory memory walker
  pidreg_otp_loader u_loader (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .o_otp_rd(o_otp_rd),
    .o_otp_addr(o_otp_addr),
    .i_otp_data(i_otp_data),
    .o_load_valid(load_valid),
    .o_load_word(load_word),
    .o_load_data(load_data),
    .o_load_done(load_done)
  );

  // port is closed until every factory word is in place
  assign o_reg_ready = load_done; // R11
  assign wr_ok = i_reg_wr & load_done; // R11
  assign rd_ok = i_reg_rd & load_done; // R11
  // both paths decode the same address; a read beside a write returns the old value
  assign wr_idx = pidreg_decode(i_reg_addr);
  assign rd_idx = pidreg_decode(i_reg_addr);

  // alternate-function select: factory value first, then software
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      alt_func_r <= PIDREG_ZERO_BYTE;
    end
    else if (load_valid && load_word == PIDREG_OTP_WORD_ALT_FUNC)
    begin
      alt_func_r <= load_data; // R11
    end
    else if (wr_ok && wr_idx == PIDREG_IDX_ALT_FUNC)
    begin
      alt_func_r <= i_reg_wdata;
    end
  end

  // serial number bytes, least significant byte at the lowest address
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      serial_low_r <= PIDREG_ZERO_BYTE;
      serial_mid_r <= PIDREG_ZERO_BYTE;
      serial_high_r <= PIDREG_ZERO_BYTE;
    end
    else if (load_valid)
    begin
      if (load_word == PIDREG_OTP_WORD_SERIAL_LOW)
        serial_low_r <= load_data; // R4
      if (load_word == PIDREG_OTP_WORD_SERIAL_MID)
        serial_mid_r <= load_data; // R4
      if (load_word == PIDREG_OTP_WORD_SERIAL_HIGH)
        serial_high_r <= load_data; // R4
    end
    else if (wr_ok)
    begin
      if (wr_idx == PIDREG_IDX_SERIAL_LOW)
        serial_low_r <= i_reg_wdata;
      if (wr_idx == PIDREG_IDX_SERIAL_MID)
        serial_mid_r <= i_reg_wdata;
      if (wr_idx == PIDREG_IDX_SERIAL_HIGH)
        serial_high_r <= i_reg_wdata;
    end
  end

  // chip revision and status: revision from silicon, status from factory memory
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      metal_rev_r <= METAL_REVISION; // R7
      prod_status_r <= PIDREG_ZERO_BYTE[PIDREG_STATUS_MSB:PIDREG_STATUS_LSB];
    end
    else if (load_valid && load_word == PIDREG_OTP_WORD_STATUS)
    begin
      prod_status_r <= load_data[PIDREG_STATUS_MSB:PIDREG_STATUS_LSB]; // R8
    end
    else if (wr_ok && wr_idx == PIDREG_IDX_REV_STATUS)
    begin
      // fields are writable; reserved codes are stored as given
      metal_rev_r <= i_reg_wdata[PIDREG_REV_MSB:PIDREG_REV_LSB];
      prod_status_r <= i_reg_wdata[PIDREG_STATUS_MSB:PIDREG_STATUS_LSB];
    end
  end

  // option tracking code
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      option_r <= PIDREG_ZERO_BYTE;
    end
    else if (load_valid && load_word == PIDREG_OTP_WORD_OPTION)
    begin
      option_r <= load_data; // R6
    end
    else if (wr_ok && wr_idx == PIDREG_IDX_OPTION)
    begin
      option_r <= i_reg_wdata;
    end
  end

  // charger configuration has a fixed reset, not a factory load
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      charger_r <= PIDREG_CHARGER_RESET;
    end
    else if (wr_ok && wr_idx == PIDREG_IDX_CHARGER)
    begin
      charger_r <= i_reg_wdata; // R10
    end
  end

  // charger field outputs come straight from the stored register
  assign o_charger_on = charger_r[PIDREG_CHG_ON_BIT]; // R9
  assign o_charger_resistor_select = charger_r[PIDREG_CHG_RES_MSB:PIDREG_CHG_RES_LSB]; // R10
  assign o_charger_low_current_disable = charger_r[PIDREG_CHG_LOWDIS_BIT]; // R10
  assign o_charger_voltage_select = charger_r[PIDREG_CHG_VOLT_MSB:PIDREG_CHG_VOLT_LSB]; // R10
  assign o_charger_current_select = charger_r[PIDREG_CHG_CUR_MSB:PIDREG_CHG_CUR_LSB]; // R10

  // read mux; unmapped addresses read as zero
  always_comb
  begin
    rdata_nxt = PIDREG_ZERO_BYTE;
    case (rd_idx)
      PIDREG_IDX_ALT_FUNC: rdata_nxt = alt_func_r;
      PIDREG_IDX_SERIAL_LOW: rdata_nxt = serial_low_r; // R5
      PIDREG_IDX_SERIAL_MID: rdata_nxt = serial_mid_r; // R5
      PIDREG_IDX_SERIAL_HIGH: rdata_nxt = serial_high_r; // R5
      PIDREG_IDX_REV_STATUS: rdata_nxt = {metal_rev_r, prod_status_r}; // R7
      PIDREG_IDX_OPTION: rdata_nxt = option_r; // R6
      PIDREG_IDX_CHARGER: rdata_nxt = charger_r;
      default: rdata_nxt = PIDREG_ZERO_BYTE;
    endcase
  end

  // read data is registered; it holds until the next accepted read
  // rvalid is a one-cycle pulse, but rdata stays so a slow reader can still pick it up
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_reg_rvalid <= 1'b0;
      o_reg_rdata <= PIDREG_ZERO_BYTE;
    end
    else
    begin
      o_reg_rvalid <= rd_ok;
      if (rd_ok)
        o_reg_rdata <= rdata_nxt;
    end
  end

  // sequencer-capable pins 0..2
  // reserved alternate bits 7..4 are stored but steer nothing in this block
  genvar g;
  generate
    for (g = 0; g < PIDREG_NUM_SEQ_PINS; g = g + 1)
    begin : g_seq_pin
      always_comb
      begin
        if (alt_func_r[g])
        begin
          o_pin_oe[g] = 1'b1; // R2
          o_pin_out[g] = i_seq_out[g]; // R2
        end
        else
        begin
          o_pin_oe[g] = ~i_first_direction_select; // R3
          o_pin_out[g] = i_gpo_level[g]; // R3
        end
      end
    end
  endgenerate

  // pin 3: power-good input in alternate mode, never driven then
  always_comb
  begin
    if (alt_func_r[PIDREG_PWRGOOD_PIN])
    begin
      o_pin_oe[PIDREG_PWRGOOD_PIN] = 1'b0; // R1
      o_pin_out[PIDREG_PWRGOOD_PIN] = 1'b0;
    end
    else
    begin
      o_pin_oe[PIDREG_PWRGOOD_PIN] = ~i_second_direction_select; // R1
      o_pin_out[PIDREG_PWRGOOD_PIN] = i_gpo_level[PIDREG_PWRGOOD_PIN];
    end
  end

  // power-good reads low when the pin is not in that role, so a stray level cannot wake anything
  assign o_external_power_good_input = alt_func_r[PIDREG_PWRGOOD_PIN] & i_pin_in[PIDREG_PWRGOOD_PIN]; // R1

  // input level is passed on for every pin; pins are taken as synchronous
  assign o_gpi_level = i_pin_in;

endmodule // pidreg_top

// File: logic/pidreg_pkg.sv
// Purpose: shared constants for the identification and pin-function register bank
// Assumes: 8-bit register port, 8-bit factory memory words
// Notes: register offsets are byte addresses on the register port
package pidreg_pkg;

  // register offsets
  localparam logic [7:0] PIDREG_ADDR_ALT_FUNC = 8'h7A;
  localparam logic [7:0] PIDREG_ADDR_CHARGER = 8'h80;
  localparam logic [7:0] PIDREG_ADDR_SERIAL_LOW = 8'hB0;
  localparam logic [7:0] PIDREG_ADDR_SERIAL_MID = 8'hB1;
  localparam logic [7:0] PIDREG_ADDR_SERIAL_HIGH = 8'hB2;
  localparam logic [7:0] PIDREG_ADDR_REV_STATUS = 8'hB3;
  localparam logic [7:0] PIDREG_ADDR_OPTION = 8'hB4;

  // register index inside the bank
  typedef enum logic [2:0] {
    PIDREG_IDX_ALT_FUNC,
    PIDREG_IDX_SERIAL_LOW,
    PIDREG_IDX_SERIAL_MID,
    PIDREG_IDX_SERIAL_HIGH,
    PIDREG_IDX_REV_STATUS,
    PIDREG_IDX_OPTION,
    PIDREG_IDX_CHARGER,
    PIDREG_IDX_NONE
  } pidreg_idx_e;

  // factory memory word addresses, loaded in this order
  localparam logic [2:0] PIDREG_OTP_WORD_ALT_FUNC = 3'h0;
  localparam logic [2:0] PIDREG_OTP_WORD_SERIAL_LOW = 3'h1;
  localparam logic [2:0] PIDREG_OTP_WORD_SERIAL_MID = 3'h2;
  localparam logic [2:0] PIDREG_OTP_WORD_SERIAL_HIGH = 3'h3;
  localparam logic [2:0] PIDREG_OTP_WORD_STATUS = 3'h4;
  localparam logic [2:0] PIDREG_OTP_WORD_OPTION = 3'h5;
  localparam logic [2:0] PIDREG_OTP_WORD_LAST = 3'h5;

  // charger configuration fields
  localparam int PIDREG_CHG_RES_MSB = 7;
  localparam int PIDREG_CHG_RES_LSB = 6;
  localparam int PIDREG_CHG_LOWDIS_BIT = 5;
  localparam int PIDREG_CHG_VOLT_MSB = 4;
  localparam int PIDREG_CHG_VOLT_LSB = 3;
  localparam int PIDREG_CHG_CUR_MSB = 2;
  localparam int PIDREG_CHG_CUR_LSB = 1;
  localparam int PIDREG_CHG_ON_BIT = 0;
  localparam logic [7:0] PIDREG_CHARGER_RESET = 8'h40;

  // chip revision and status fields
  localparam int PIDREG_REV_MSB = 7;
  localparam int PIDREG_REV_LSB = 4;
  localparam int PIDREG_STATUS_MSB = 3;
  localparam int PIDREG_STATUS_LSB = 0;

  // pins handled here and the alternate-function bit of the power-good pin
  localparam int PIDREG_NUM_PINS = 4;
  localparam int PIDREG_NUM_SEQ_PINS = 3;
  localparam int PIDREG_PWRGOOD_PIN = 3;

  // reset value of bank registers before the factory load
  localparam logic [7:0] PIDREG_ZERO_BYTE = 8'h00;

endpackage

// File: logic/pidreg_otp_loader.sv
// Purpose: walks the factory memory once after reset and hands each word to the bank
// Assumes: factory memory returns data one cycle after its read strobe
// Notes: o_load_done stays high until the next reset
`timescale 1ns/1ps

module pidreg_otp_loader
  import pidreg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // factory memory side
  output logic o_otp_rd,
  output logic [2:0] o_otp_addr,
  input wire logic [7:0] i_otp_data,
  // bank side
  output logic o_load_valid,
  output logic [2:0] o_load_word,
  output logic [7:0] o_load_data,
  output logic o_load_done
);

  typedef enum logic [1:0] {
    PIDREG_LD_REQ,
    PIDREG_LD_CAP,
    PIDREG_LD_DONE
  } pidreg_ld_e;

  pidreg_ld_e state_r;
  logic [2:0] word_r;

  // sequencer: request a word, capture it, move on until the last one
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state_r <= PIDREG_LD_REQ;
      word_r <= PIDREG_OTP_WORD_ALT_FUNC;
    end
    else
    begin
      case (state_r)
        PIDREG_LD_REQ:
        begin
          state_r <= PIDREG_LD_CAP;
        end
        PIDREG_LD_CAP:
        begin
          if (word_r == PIDREG_OTP_WORD_LAST)
          begin
            state_r <= PIDREG_LD_DONE;
          end
          else
          begin
            word_r <= word_r + 3'h1;
            state_r <= PIDREG_LD_REQ;
          end
        end
        default:
        begin
          state_r <= PIDREG_LD_DONE;
        end
      endcase
    end
  end

  // captured word is registered so the bank sees clean data
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_load_valid <= 1'b0;
      o_load_word <= 3'h0;
      o_load_data <= PIDREG_ZERO_BYTE;
    end
    else
    begin
      o_load_valid <= (state_r == PIDREG_LD_CAP);
      o_load_word <= word_r;
      o_load_data <= i_otp_data;
    end
  end

  // done rises one cycle after the last word is delivered, never earlier
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_load_done <= 1'b0;
    end
    else if (state_r == PIDREG_LD_DONE)
    begin
      o_load_done <= 1'b1;
    end
  end

  assign o_otp_rd = (state_r == PIDREG_LD_REQ);
  assign o_otp_addr = word_r;

endmodule // pidreg_otp_loader

// File: verif/pidreg_props.sv
// Purpose: port-level properties of the identification and pin-function register bank
// Assumes: one clock, synchronous active-high reset
// Notes: attached to pidreg_top by the bind at the foot of this file
`timescale 1ns/1ps

module pidreg_props
  import pidreg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port and factory memory strobe
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic o_reg_ready,
  input wire logic o_reg_rvalid,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_otp_rd,
  // pins
  input wire logic i_first_direction_select,
  input wire logic [3:0] i_gpo_level,
  input wire logic [2:0] i_seq_out,
  input wire logic [3:0] i_pin_in,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe,
  input wire logic [3:0] o_gpi_level,
  input wire logic o_external_power_good_input,
  // charger controls
  input wire logic o_charger_on,
  input wire logic [1:0] o_charger_resistor_select,
  input wire logic o_charger_low_current_disable,
  input wire logic [1:0] o_charger_voltage_select,
  input wire logic [1:0] o_charger_current_select
);
  // charger outputs regathered in register bit order
  logic [7:0] chg_view;
  assign chg_view = {o_charger_resistor_select, o_charger_low_current_disable, o_charger_voltage_select,
    o_charger_current_select, o_charger_on};

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // accepted accesses; a strobe while the port is closed must leave no trace
  sequence s_read;
    i_reg_rd && o_reg_ready;
  endsequence
  sequence s_chg_write;
    i_reg_wr && o_reg_ready && i_reg_addr == PIDREG_ADDR_CHARGER;
  endsequence

  a_read_answer: assert property (s_read |=> o_reg_rvalid) else $error("read without rvalid");
  a_rvalid_cause: assert property (!(i_reg_rd && o_reg_ready) |=> !o_reg_rvalid)
    else $error("rvalid without accepted read");
  a_rdata_hold: assert property (!(i_reg_rd && o_reg_ready) |=> $stable(o_reg_rdata))
    else $error("rdata moved without read");
  a_charger_write: assert property (s_chg_write |=> chg_view == $past(i_reg_wdata))
    else $error("charger fields differ from written byte");
  a_charger_hold: assert property (!(i_reg_wr && o_reg_ready && i_reg_addr == PIDREG_ADDR_CHARGER)
    |=> $stable(chg_view)) else $error("charger fields moved without write");
  a_ready_sticky: assert property (o_reg_ready |=> o_reg_ready) else $error("port closed again");
  a_load_first: assert property (o_reg_ready |-> !o_otp_rd) else $error("factory read after port open");
  a_power_good: assert property (o_external_power_good_input |-> i_pin_in[3] && !o_pin_oe[3])
    else $error("power good without input pin");
  a_seq_pins: assert property (i_first_direction_select |->
    ((o_pin_out[2:0] ^ i_seq_out) & o_pin_oe[2:0]) == 3'h0) else $error("driven pin not from sequencer");
  a_plain_drive: assert property (!i_first_direction_select |-> o_pin_oe[2:0] == 3'h7)
    else $error("output pin not driven");
  a_pin3_plain: assert property (o_pin_oe[3] |-> o_pin_out[3] == i_gpo_level[3])
    else $error("pin 3 drive wrong");
  a_gpi_follow: assert property (o_gpi_level == i_pin_in) else $error("input level mismatch");
endmodule // pidreg_props

bind pidreg_top pidreg_props u_pidreg_props (.i_core_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_ready, .o_reg_rvalid, .o_reg_rdata, .o_otp_rd, .i_first_direction_select,
  .i_gpo_level, .i_seq_out, .i_pin_in, .o_pin_out, .o_pin_oe, .o_gpi_level, .o_external_power_good_input,
  .o_charger_on, .o_charger_resistor_select, .o_charger_low_current_disable, .o_charger_voltage_select,
  .o_charger_current_select);

// File: verif/pidreg_top_tb.sv
// Purpose: directed register and pin tests of the identification and pin-function bank
// Assumes: factory memory answers one cycle after its strobe; inputs change on falling edges
// Notes: factory contents and metal revision are test patterns
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module pidreg_top_tb;
  import pidreg_pkg::*;
  // metal revision; value is arbitrary
  localparam logic [3:0] METAL = 4'h5;
  logic [7:0] otp_mem [0:5] = '{8'h05, 8'h3C, 8'h5A, 8'hC3, 8'hE7, 8'h96};
  logic [7:0] chg_vals [0:3] = '{8'h01, 8'hFE, 8'hAA, 8'h55};
  logic i_core_clk, i_reset, i_reg_wr, i_reg_rd, o_reg_ready, o_reg_rvalid, o_otp_rd;
  logic i_first_direction_select, i_second_direction_select, o_external_power_good_input;
  logic o_charger_on, o_charger_low_current_disable;
  logic [1:0] o_charger_resistor_select, o_charger_voltage_select, o_charger_current_select;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_otp_data, chg_view;
  logic [2:0] o_otp_addr, i_seq_out;
  logic [3:0] i_gpo_level, i_pin_in, o_pin_out, o_pin_oe, o_gpi_level, eo, ev;
  int mismatches = 0;
  int checks_done = 0;

  pidreg_top #(.METAL_REVISION(METAL)) u_pidreg_top (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_ready(o_reg_ready), .o_reg_rvalid(o_reg_rvalid), .o_reg_rdata(o_reg_rdata),
    .o_otp_rd(o_otp_rd), .o_otp_addr(o_otp_addr), .i_otp_data(i_otp_data),
    .i_first_direction_select(i_first_direction_select), .i_second_direction_select(i_second_direction_select),
    .i_gpo_level(i_gpo_level), .i_seq_out(i_seq_out), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_gpi_level(o_gpi_level), .o_external_power_good_input(o_external_power_good_input),
    .o_charger_on(o_charger_on), .o_charger_resistor_select(o_charger_resistor_select),
    .o_charger_low_current_disable(o_charger_low_current_disable),
    .o_charger_voltage_select(o_charger_voltage_select), .o_charger_current_select(o_charger_current_select));

  assign chg_view = {o_charger_resistor_select, o_charger_low_current_disable, o_charger_voltage_select,
    o_charger_current_select, o_charger_on};

  // 250 MHz clock
  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // factory memory: word follows the held address, ready well before the capture edge
  always @(negedge i_core_clk)
    i_otp_data <= otp_mem[o_otp_addr];

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard far above the longest sequence
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    complete_run();
  end

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_core_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = addr;
    i_reg_wdata = data;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] addr, input logic [7:0] ex);
    @(negedge i_core_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = addr;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    `CHK("rvalid", 1'b1, o_reg_rvalid)
    `CHK($sformatf("read %0h", addr), ex, o_reg_rdata)
  endtask

  // reset, then a read and a charger write strobe that the still closed port must drop
  task automatic reset_and_load();
    i_reset = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_reset = 1'b0;
    `CHK("ready early", 1'b0, o_reg_ready)
    `CHK("charger reset", 8'h40, chg_view)
    i_reg_rd = 1'b1;
    i_reg_wr = 1'b1;
    i_reg_addr = PIDREG_ADDR_CHARGER;
    i_reg_wdata = 8'hFF;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    i_reg_wr = 1'b0;
    `CHK("refused read", 1'b0, o_reg_rvalid)
    for (int n = 0; n < 100 && o_reg_ready !== 1'b1; n++)
      @(negedge i_core_clk);
    `CHK("ready", 1'b1, o_reg_ready)
    `CHK("refused write", 8'h40, chg_view)
    if (o_reg_ready !== 1'b1)
      complete_run();
  endtask

  initial
  begin
    i_reset = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_otp_data = 8'h00;
    i_first_direction_select = 1'b0;
    i_second_direction_select = 1'b0;
    i_gpo_level = 4'h0;
    i_seq_out = 3'h0;
    i_pin_in = 4'h0;
    reset_and_load();
    reg_read(PIDREG_ADDR_ALT_FUNC, otp_mem[0]);
    reg_read(PIDREG_ADDR_SERIAL_LOW, otp_mem[1]);
    reg_read(PIDREG_ADDR_SERIAL_MID, otp_mem[2]);
    reg_read(PIDREG_ADDR_SERIAL_HIGH, otp_mem[3]);
    reg_read(PIDREG_ADDR_REV_STATUS, {METAL, otp_mem[4][3:0]});
    reg_read(PIDREG_ADDR_OPTION, otp_mem[5]);
    reg_read(8'h81, 8'h00);
    reg_read(PIDREG_ADDR_CHARGER, 8'h40);
    // every field of the charger byte toggled both ways
    for (int i = 0; i < 4; i++)
    begin
      reg_write(PIDREG_ADDR_CHARGER, chg_vals[i]);
      `CHK("charger fields", chg_vals[i], chg_view)
      reg_read(PIDREG_ADDR_CHARGER, chg_vals[i]);
    end
    // all alternate-function patterns against both direction settings
    for (int a = 0; a < 16; a++)
    begin
      reg_write(PIDREG_ADDR_ALT_FUNC, 8'(a));
      for (int d = 0; d < 4; d++)
      begin
        // each setting starts on a falling edge, well clear of the sampling edge
        @(negedge i_core_clk);
        i_first_direction_select = d[0];
        i_second_direction_select = d[1];
        i_pin_in = {d[0], 3'(a)};
        i_gpo_level = 4'(a + d);
        i_seq_out = ~3'(a + d);
        eo = {~a[3] & ~d[1], a[2:0] | {3{~d[0]}}};
        ev = {i_gpo_level[3], (i_seq_out & 3'(a)) | (i_gpo_level[2:0] & ~3'(a))};
        #1;
        `CHK("pin oe", eo, o_pin_oe)
        `CHK("pin out", ev & eo, o_pin_out & eo)
        `CHK("power good", a[3] & d[0], o_external_power_good_input)
        `CHK("pin in", i_pin_in, o_gpi_level)
      end
    end
    reg_write(PIDREG_ADDR_SERIAL_LOW, 8'h11);
    reg_read(PIDREG_ADDR_SERIAL_LOW, 8'h11);
    // second reset in mid run reloads the factory words
    reset_and_load();
    reg_read(PIDREG_ADDR_SERIAL_LOW, otp_mem[1]);
    reg_read(PIDREG_ADDR_SERIAL_HIGH, otp_mem[3]);
    complete_run();
  end
endmodule // pidreg_top_tb
